// [core/tw_master.sv]
// Calling end: byte transfers, clock sync, arbitration, slave receive fallback
//
// Notes on behaviour
// - Bytes follow direction of address R/W bit
// - Eight bits per byte, MSB first
// - SDA changes only while SCL is low, except at start and stop
// - Ninth clock carries receiver acknowledge low
// - Missing slave acknowledge means failed transfer
// - Missing master acknowledge ends slave transmission
// - After abort, only stop or repeated start
// - Stop is SDA rising while SCL high
// - Stop allowed after acknowledge; slave releases
// - Repeated start keeps the bus
// - SCL low longest, high shortest
// - Sent one seen zero means lost arbitration
// - Loser releases SDA, becomes slave receiver
`timescale 1ns/1ps
`default_nettype none
module tw_master
  import tw_pkg::*;
#(
  parameter int LOW_CYCLES = LOW_CYC,
  parameter int HIGH_CYCLES = HIGH_CYC,
  parameter int BUF_CYCLES = BUF_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  tw_if.master bus,
  input wire logic cmd_valid_in,
  input wire tw_cmd_t cmd_in,
  input wire logic [7:0] data_in,
  input wire logic no_ack_in,
  output logic cmd_ready_out,
  output logic busy_out,
  output logic done_out,
  output logic nack_out,
  output logic lost_out,
  output logic [7:0] rdata_out,
  output logic srx_valid_out,
  output logic [7:0] srx_data_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    M_IDLE, M_HOLD, M_RS, M_START_A, M_START_B, M_LOW, M_HIGH,
    M_STOP_A, M_STOP_B, M_STOP_C, M_SLAVE
  } tw_mst_state_t;

  typedef struct packed {
    tw_mst_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic rw;
    logic rx_byte;
    logic give_nack;
    logic aborted;
    logic samp;
    logic bus_busy;
    logic scl_m;
    logic sda_m;
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
    logic scl_oe;
    logic sda_oe;
    logic cmd_ready;
    logic busy;
    logic done;
    logic nack;
    logic lost;
    logic [7:0] rdata;
    logic srx_valid;
    logic [7:0] srx_data;
  } tw_mst_regs_t;

  localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(HIGH_CYCLES - 1);
  localparam logic [CNT_W-1:0] BUF_LAST = CNT_W'(BUF_CYCLES - 1);

  tw_mst_regs_t r;
  tw_mst_regs_t n;
  logic start_seen;
  logic stop_seen;
  logic high_end;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.done = 1'b0;
    n.lost = 1'b0;
    n.srx_valid = 1'b0;
    n.cnt = r.cnt + CNT_W'(1);
    n.scl_m = bus.scl;
    n.sda_m = bus.sda;
    n.scl_s = r.scl_m;
    n.sda_s = r.sda_m;
    n.scl_p = r.scl_s;
    n.sda_p = r.sda_s;
    start_seen = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
    stop_seen = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
    // High phase ends at our count or when another master pulls low
    high_end = (r.scl_s && r.cnt == HIGH_LAST) || (!r.scl_s && r.cnt != '0);
    if (start_seen)
    begin
      n.bus_busy = 1'b1;
    end
    if (stop_seen)
    begin
      n.bus_busy = 1'b0;
    end
    case (r.st)
      M_IDLE:
      begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        n.aborted = 1'b0;
        if (cmd_valid_in && r.cmd_ready && cmd_in == TW_CMD_START)
        begin
          n.shreg = data_in;
          n.rw = data_in[0];
          n.st = M_START_A;
          n.cnt = '0;
        end
      end
      M_HOLD:
      begin
        // SCL kept low while the bus is ours and idle
        n.scl_oe = 1'b1;
        n.cnt = '0;
        n.bitn = 4'h0;
        if (cmd_valid_in)
        begin
          case (cmd_in)
            TW_CMD_START:
            begin
              n.shreg = data_in;
              n.rw = data_in[0];
              n.aborted = 1'b0;
              n.st = M_RS;
            end
            TW_CMD_WRITE:
            begin
              if (!r.aborted && !r.rw)
              begin
                n.shreg = data_in;
                n.rx_byte = 1'b0;
                n.st = M_LOW;
              end
            end
            TW_CMD_READ:
            begin
              if (!r.aborted && r.rw)
              begin
                n.rx_byte = 1'b1;
                n.give_nack = no_ack_in;
                n.st = M_LOW;
              end
            end
            default:
            begin
              n.st = M_STOP_A;
            end
          endcase
        end
      end
      M_RS:
      begin
        // Release SDA first while SCL is still low
        n.sda_oe = 1'b0;
        if (r.cnt == LOW_LAST)
        begin
          n.scl_oe = 1'b0;
          n.st = M_START_A;
          n.cnt = '0;
        end
      end
      M_START_A:
      begin
        if (start_seen)
        begin
          n.lost = 1'b1;
          n.st = M_SLAVE;
          n.bitn = 4'h0;
        end
        else if (!(r.scl_s && r.sda_s))
        begin
          n.cnt = '0;
        end
        else if (r.cnt == HIGH_LAST)
        begin
          n.sda_oe = 1'b1;
          n.st = M_START_B;
          n.cnt = '0;
        end
      end
      M_START_B:
      begin
        if (r.cnt == HIGH_LAST)
        begin
          n.scl_oe = 1'b1;
          n.rx_byte = 1'b0;
          n.bitn = 4'h0;
          n.st = M_LOW;
          n.cnt = '0;
        end
      end
      M_LOW:
      begin
        n.scl_oe = 1'b1;
        if (r.cnt == '0)
        begin
          if (r.bitn == ACK_BIT)
          begin
            n.sda_oe = r.rx_byte & ~r.give_nack;
          end
          else
          begin
            n.sda_oe = ~r.rx_byte & ~r.shreg[7];
          end
        end
        if (r.cnt == LOW_LAST)
        begin
          n.scl_oe = 1'b0;
          n.st = M_HIGH;
          n.cnt = '0;
        end
      end
      M_HIGH:
      begin
        if (!r.scl_s)
        begin
          // Held low elsewhere: wait, this stretches the low phase
          n.cnt = r.cnt;
        end
        if (r.scl_s && r.cnt == '0)
        begin
          n.samp = r.sda_s;
        end
        if (r.scl_s && !r.rx_byte && r.bitn <= LAST_DATA_BIT && !r.sda_oe && !r.sda_s)
        begin
          n.lost = 1'b1;
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
          n.shreg = {r.shreg[6:0], 1'b0};
          n.bitn = r.bitn + 4'h1;
          n.st = M_SLAVE;
        end
        else if (high_end)
        begin
          n.scl_oe = 1'b1;
          n.cnt = '0;
          if (r.bitn <= LAST_DATA_BIT)
          begin
            n.shreg = {r.shreg[6:0], n.samp};
            n.bitn = r.bitn + 4'h1;
            n.st = M_LOW;
          end
          else
          begin
            n.done = 1'b1;
            n.st = M_HOLD;
            if (r.rx_byte)
            begin
              n.rdata = r.shreg;
              n.nack = 1'b0;
              n.aborted = r.give_nack;
            end
            else
            begin
              n.nack = n.samp;
              n.aborted = n.samp;
            end
          end
        end
      end
      M_STOP_A:
      begin
        n.scl_oe = 1'b1;
        n.sda_oe = 1'b1;
        if (r.cnt == LOW_LAST)
        begin
          n.scl_oe = 1'b0;
          n.st = M_STOP_B;
          n.cnt = '0;
        end
      end
      M_STOP_B:
      begin
        if (!r.scl_s)
        begin
          n.cnt = '0;
        end
        else if (r.cnt == HIGH_LAST)
        begin
          n.sda_oe = 1'b0;
          n.st = M_STOP_C;
          n.cnt = '0;
        end
      end
      M_STOP_C:
      begin
        // Bus free time before a new start may be made
        if (r.cnt == BUF_LAST)
        begin
          n.st = M_IDLE;
        end
      end
      M_SLAVE:
      begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        if (stop_seen)
        begin
          n.st = M_IDLE;
        end
        else if (start_seen)
        begin
          n.bitn = 4'h0;
        end
        else if (r.scl_s && !r.scl_p)
        begin
          if (r.bitn <= LAST_DATA_BIT)
          begin
            n.shreg = {r.shreg[6:0], r.sda_s};
            n.bitn = r.bitn + 4'h1;
            if (r.bitn == LAST_DATA_BIT)
            begin
              n.srx_data = {r.shreg[6:0], r.sda_s};
              n.srx_valid = 1'b1;
            end
          end
          else
          begin
            n.bitn = 4'h0;
          end
        end
      end
      default:
      begin
        n.st = M_IDLE;
      end
    endcase
    n.busy = (n.st != M_IDLE);
    n.cmd_ready = (n.st == M_HOLD) || (n.st == M_IDLE && !n.bus_busy);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = r.scl_oe;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = r.sda_oe;
  assign cmd_ready_out = r.cmd_ready;
  assign busy_out = r.busy;
  assign done_out = r.done;
  assign nack_out = r.nack;
  assign lost_out = r.lost;
  assign rdata_out = r.rdata;
  assign srx_valid_out = r.srx_valid;
  assign srx_data_out = r.srx_data;

endmodule
`default_nettype wire

// [core/tw_pkg.sv]
// Shared constants and types for the two-wire byte transfer ends
package tw_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_LOW_NS = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam int T_BUF_NS = 4700;
  // Least times, rounded up to whole cycles
  localparam int LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUF_CYC = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;

  // ----------------------------------------------------------------
  // Commands of the calling end
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TW_CMD_START,
    TW_CMD_WRITE,
    TW_CMD_READ,
    TW_CMD_STOP
  } tw_cmd_t;

endpackage

// [core/tw_if.sv]
// Open-drain two-wire bus joining the calling end and the slave end
`timescale 1ns/1ps
`default_nettype none
interface tw_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  // Pull-downs of further parties on the wire; the bench must drive them
  logic x_scl_oe;
  logic x_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND: any enabled low driver wins, otherwise the pull-up
  assign scl = (m_scl_oe ? m_scl_o : 1'b1) & ~x_scl_oe;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1) & ~x_sda_oe;

  modport master (
    input scl,
    input sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );

  modport slave (
    input scl,
    input sda,
    output s_sda_o,
    output s_sda_oe
  );
endinterface
`default_nettype wire

// [core/tw_slave.sv]
// Slave end: addressed receiver and transmitter on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tw_slave
  import tw_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = SLAVE_ADDR_DEFAULT
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  tw_if.slave bus,
  input wire logic [7:0] tx_data_in,
  output logic tx_taken_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic selected_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_WAIT} tw_slv_state_t;

  typedef struct packed {
    tw_slv_state_t st;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic rw;
    logic scl_m;
    logic sda_m;
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic tx_taken;
    logic [7:0] rx_data;
    logic rx_valid;
    logic selected;
  } tw_slv_regs_t;

  tw_slv_regs_t r;
  tw_slv_regs_t n;
  logic start_seen;
  logic stop_seen;
  logic rise;
  logic fall;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.tx_taken = 1'b0;
    n.rx_valid = 1'b0;
    n.scl_m = bus.scl;
    n.sda_m = bus.sda;
    n.scl_s = r.scl_m;
    n.sda_s = r.sda_m;
    n.scl_p = r.scl_s;
    n.sda_p = r.sda_s;
    start_seen = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
    stop_seen = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
    rise = r.scl_s & ~r.scl_p;
    fall = ~r.scl_s & r.scl_p;
    if (start_seen)
    begin
      n.st = S_ADDR;
      n.bitn = 4'h0;
      n.sda_oe = 1'b0;
    end
    else if (stop_seen)
    begin
      // Stop may come right after our acknowledge
      n.st = S_IDLE;
      n.sda_oe = 1'b0;
    end
    else if (r.st != S_IDLE && r.st != S_WAIT)
    begin
      if (rise)
      begin
        if (r.bitn <= LAST_DATA_BIT)
        begin
          if (r.st != S_TX)
          begin
            n.shreg = {r.shreg[6:0], r.sda_s};
          end
          n.bitn = r.bitn + 4'h1;
        end
        else if (r.st == S_TX && r.sda_s)
        begin
          // No acknowledge from the calling end closes the read
          n.st = S_WAIT;
        end
        else
        begin
          // Count the ninth clock so its falling edge closes the byte
          n.bitn = r.bitn + 4'h1;
        end
      end
      else if (fall)
      begin
        // Data only moves while SCL is low
        if (r.bitn == ACK_BIT)
        begin
          case (r.st)
            S_ADDR:
            begin
              if (r.shreg[7:1] == OWN_ADDR)
              begin
                n.rw = r.shreg[0];
                n.sda_oe = 1'b1;
              end
              else
              begin
                n.st = S_WAIT;
              end
            end
            S_RX:
            begin
              n.rx_data = r.shreg;
              n.rx_valid = 1'b1;
              n.sda_oe = 1'b1;
            end
            default:
            begin
              n.sda_oe = 1'b0;
            end
          endcase
        end
        else if (r.bitn == ACK_BIT + 4'h1)
        begin
          n.bitn = 4'h0;
          if (r.st == S_TX || (r.st == S_ADDR && r.rw))
          begin
            n.st = S_TX;
            n.shreg = tx_data_in;
            n.tx_taken = 1'b1;
            n.sda_oe = ~tx_data_in[7];
          end
          else
          begin
            n.st = S_RX;
            n.sda_oe = 1'b0;
          end
        end
        else if (r.st == S_TX && r.bitn != 4'h0)
        begin
          n.sda_oe = ~r.shreg[3'h7 - r.bitn[2:0]];
        end
      end
    end
    else
    begin
      n.sda_oe = 1'b0;
    end
    n.selected = (n.st == S_RX) | (n.st == S_TX);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = r.sda_oe;
  assign tx_taken_out = r.tx_taken;
  assign rx_data_out = r.rx_data;
  assign rx_valid_out = r.rx_valid;
  assign selected_out = r.selected;

endmodule
`default_nettype wire

// [verification/tw_properties.sv]
// Wire-level checks on the two-wire bus joining the two ends
`timescale 1ns/1ps
`default_nettype none
module tw_properties
#(
  parameter int LOW_CYCLES = 8,
  parameter int HIGH_CYCLES = 8,
  parameter logic [6:0] OWN_ADDR = 7'h2A
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic x_scl_oe,
  input wire logic x_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // Wire tracking
  // ----------------------------------------------------------------
  logic scl_q;
  logic sda_q;
  logic first;
  logic [3:0] nbit;
  logic [7:0] sh;
  logic [7:0] lcnt;
  logic [7:0] hcnt;
  wire logic scl_rise = scl && !scl_q;
  wire logic edge_ev = scl && scl_q && (sda != sda_q);

  // Any SDA edge under high SCL restarts the count; only a falling one opens an address
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      nbit <= 4'h0;
      sh <= 8'h00;
      lcnt <= 8'h00;
      hcnt <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (edge_ev)
      begin
        nbit <= 4'h0;
        first <= sda_q;
      end
      else if (scl_rise && nbit == 4'h8)
      begin
        nbit <= 4'h0;
        first <= 1'b0;
      end
      else if (scl_rise)
      begin
        nbit <= nbit + 4'h1;
        sh <= {sh[6:0], sda};
      end
      lcnt <= !m_scl_oe ? 8'h00 : (lcnt == 8'hFF ? lcnt : lcnt + 8'h01);
      hcnt <= (m_scl_oe || !scl) ? 8'h00 : (hcnt == 8'hFF ? hcnt : hcnt + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_slave_low_change: assert property (
    $changed(s_sda_oe) |-> !scl && !scl_q)
    else $error("slave moved SDA while SCL high");
  a_sda_steady_high: assert property (
    edge_ev |-> $changed(m_sda_oe) || $changed(x_sda_oe))
    else $error("SDA moved under high SCL without a master");
  a_address_ack: assert property (
    scl_rise && nbit == 4'h8 && first && sh[7:1] == OWN_ADDR |-> s_sda_oe)
    else $error("own address not acknowledged");
  a_foreign_quiet: assert property (
    scl_rise && nbit == 4'h8 && first && sh[7:1] != OWN_ADDR |-> !s_sda_oe)
    else $error("foreign address acknowledged");
  a_nack_release: assert property (
    scl_rise && nbit == 4'h8 && sda |-> ##8 (!s_sda_oe) [*8])
    else $error("slave drove SDA after missing acknowledge");
  a_low_min: assert property (
    $fell(m_scl_oe) |-> lcnt >= LOW_CYCLES)
    else $error("SCL low phase too short");
  a_high_min: assert property (
    $rose(m_scl_oe) && scl_q |-> hcnt >= HIGH_CYCLES)
    else $error("SCL high phase cut short");
  a_loser_quiet: assert property (
    scl && x_sda_oe && !m_sda_oe && !m_scl_oe |-> ##4 (!m_sda_oe && !m_scl_oe) [*8])
    else $error("master kept driving after losing");
endmodule
`default_nettype wire

// [verification/two_wire_bus_byte_transfer_tb.sv]
// Bench: calling end and slave end joined on one two-wire bus
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_byte_transfer_tb;
  import tw_pkg::*;
  localparam int PH = 8;
  localparam logic [7:0] RIVAL = 8'h20;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid = 1'b0;
  tw_cmd_t cmd = TW_CMD_START;
  logic [7:0] data = 8'h00;
  logic no_ack = 1'b0;
  logic [7:0] tx_data = 8'h3C;
  logic ready, busy, done, nack, lost, srx_valid, tx_taken, rx_valid, selected;
  logic [7:0] rdata, srx_data, rx_data, rx_last, srx_last;
  logic [8:0] mon = 9'h000;
  int starts = 0, stops = 0, bad_count = 0, comparisons = 0;

  tw_if bus();
  tw_master #(.LOW_CYCLES(PH), .HIGH_CYCLES(PH), .BUF_CYCLES(PH)) i_tw_master (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .data_in(data), .no_ack_in(no_ack), .cmd_ready_out(ready),
    .busy_out(busy), .done_out(done), .nack_out(nack), .lost_out(lost),
    .rdata_out(rdata), .srx_valid_out(srx_valid), .srx_data_out(srx_data));
  tw_slave i_tw_slave (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus), .tx_data_in(tx_data),
    .tx_taken_out(tx_taken), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .selected_out(selected));
  tw_properties #(.LOW_CYCLES(PH), .HIGH_CYCLES(PH), .OWN_ADDR(SLAVE_ADDR_DEFAULT))
  i_tw_properties (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .m_scl_oe(bus.m_scl_oe), .m_sda_oe(bus.m_sda_oe),
    .s_sda_oe(bus.s_sda_oe), .x_scl_oe(bus.x_scl_oe), .x_sda_oe(bus.x_sda_oe),
    .scl(bus.scl), .sda(bus.sda));

  always #10 clk_in = ~clk_in;

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Flipping the byte on every take shows which value each read bit came from
  always @(posedge clk_in)
  begin
    if (tx_taken === 1'b1) tx_data <= ~tx_data;
    if (rx_valid === 1'b1) rx_last <= rx_data;
    if (srx_valid === 1'b1) srx_last <= srx_data;
  end
  always @(posedge bus.scl) mon <= {mon[7:0], bus.sda};
  always @(negedge bus.sda) if (bus.scl === 1'b1 && rst_n_in === 1'b1) starts++;
  always @(posedge bus.sda) if (bus.scl === 1'b1 && rst_n_in === 1'b1) stops++;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic take(input tw_cmd_t c, input logic [7:0] d, input logic na);
    int n = 0;
    @(posedge clk_in);
    while (ready !== 1'b1 && n < 2000)
    begin
      @(posedge clk_in);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd <= c;
    data <= d;
    no_ack <= na;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
  endtask

  task automatic send(input tw_cmd_t c, input logic [7:0] d, input logic na);
    int n = 0;
    take(c, d, na);
    while (n < 2000 && (c == TW_CMD_STOP ? busy !== 1'b0 : done !== 1'b1))
    begin
      @(posedge clk_in);
      n++;
    end
    check(9'(n == 2000), 9'h000, "no completion");
  endtask

  task automatic refuse(input tw_cmd_t c, input logic b);
    int n = 0;
    take(c, 8'hFF, 1'b0);
    repeat (60)
    begin
      @(posedge clk_in);
      if (done === 1'b1) n++;
    end
    check({7'h00, ready, busy}, {7'h00, 1'b1, b}, "refused state");
    check(9'(n), 9'h000, "refused command ran");
  endtask

  // One 160 ns bit of a rival master, half the bench's 320 ns link period
  task automatic rival_bit(input logic pull);
    bus.x_scl_oe <= 1'b1;
    @(posedge clk_in);
    bus.x_sda_oe <= pull;
    repeat (3) @(posedge clk_in);
    bus.x_scl_oe <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic write_test;
    refuse(TW_CMD_WRITE, 1'b0);
    send(TW_CMD_START, 8'h54, 1'b0);
    check({8'h00, nack}, 9'h000, "address ack");
    check(9'(starts), 9'h001, "start count");
    send(TW_CMD_WRITE, 8'hA5, 1'b0);
    check(mon, 9'h14A, "wire bits");
    repeat (8) @(posedge clk_in);
    check({1'b0, rx_last}, 9'h0A5, "slave byte");
    send(TW_CMD_WRITE, 8'h01, 1'b0);
    send(TW_CMD_STOP, 8'h00, 1'b0);
    check({1'b0, rx_last}, 9'h001, "slave byte");
    check(9'(stops), 9'h001, "stop count");
    check({8'h00, selected}, 9'h000, "slave released");
  endtask

  task automatic read_test;
    send(TW_CMD_START, 8'h55, 1'b0);
    check({8'h00, nack}, 9'h000, "read address ack");
    send(TW_CMD_READ, 8'h00, 1'b0);
    check({1'b0, rdata}, 9'h03C, "first read byte");
    send(TW_CMD_READ, 8'h00, 1'b1);
    check({1'b0, rdata}, 9'h0C3, "last read byte");
    refuse(TW_CMD_READ, 1'b1);
    refuse(TW_CMD_WRITE, 1'b1);
    send(TW_CMD_START, 8'h54, 1'b0);
    check({7'h00, nack, busy}, 9'h001, "repeated start");
    check(9'(stops), 9'h001, "bus kept");
    send(TW_CMD_STOP, 8'h00, 1'b0);
    check(9'(starts), 9'h003, "start count");
  endtask

  // Rival holds SCL low past our low phase; our high phase must wait for it
  task automatic sync_test;
    int n = 0;
    send(TW_CMD_START, 8'h54, 1'b0);
    take(TW_CMD_WRITE, 8'h96, 1'b0);
    bus.x_scl_oe <= 1'b1;
    repeat (40) @(posedge clk_in);
    bus.x_scl_oe <= 1'b0;
    @(posedge clk_in);
    while (bus.scl === 1'b1 && n < 100)
    begin
      @(posedge clk_in);
      n++;
    end
    check(9'(n >= PH), 9'h001, "high after stretch");
    n = 0;
    while (done !== 1'b1 && n < 2000)
    begin
      @(posedge clk_in);
      n++;
    end
    check({nack, rx_last}, 9'h096, "byte after stretch");
    check(mon, 9'h12C, "stretched wire bits");
    send(TW_CMD_STOP, 8'h00, 1'b0);
  endtask

  task automatic nack_test;
    send(TW_CMD_START, 8'h12, 1'b0);
    check({8'h00, nack}, 9'h001, "foreign address");
    refuse(TW_CMD_WRITE, 1'b1);
    send(TW_CMD_STOP, 8'h00, 1'b0);
    check({8'h00, busy}, 9'h000, "bus freed");
  endtask

  task automatic arb_test;
    int n = 0;
    take(TW_CMD_START, 8'h54, 1'b0);
    repeat (2) @(negedge bus.scl);
    repeat (2) @(posedge clk_in);
    bus.x_sda_oe <= 1'b1;
    while (lost !== 1'b1 && n < 200)
    begin
      @(posedge clk_in);
      n++;
    end
    check({8'h00, lost}, 9'h001, "arbitration loss");
    @(posedge clk_in);
    check({7'h00, bus.m_sda_oe, bus.m_scl_oe}, 9'h000, "loser lines");
    for (int i = 5; i >= 0; i--) rival_bit(~RIVAL[i]);
    rival_bit(1'b0);
    rival_bit(1'b1);
    bus.x_sda_oe <= 1'b0;
    repeat (20) @(posedge clk_in);
    check({1'b0, srx_last}, {1'b0, RIVAL}, "slave receive byte");
    check({8'h00, busy}, 9'h000, "idle after stop");
  endtask

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    bus.x_scl_oe = 1'b0;
    bus.x_sda_oe = 1'b0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    write_test();
    read_test();
    sync_test();
    nack_test();
    arb_test();
    stop_test();
  end

  initial
  begin
    #500000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
